// File: rtc_irq_backup.sv
// interrupt, compensation-interval and backup-switch logic of the clock
// assumes a serial engine on linkClk feeding the byte register port and
// calendar compare logic on clk feeding the alarm match levels
// Function
// (R1) writing run one starts countdown from preset
// (R2) each event reloads preset and keeps counting
// (R3) timer event sets sticky timer flag
// (R4) timer pulse drives pin only if enabled
// (R5) timer pulse self-releases after pulse time
// (R6) run zero stops timer and releases pin
// (R7) flag clear keeps pulse; enable clear releases
// (R8) update event each second or minute
// (R9) update event sets sticky update flag
// (R10) update pulse fixed width when enabled
// (R11) flag clear keeps pulse; enable clear releases
// (R12) alarm fires only on advance into match
// (R13) alarm sets flag, holds pin low
// (R14) alarm flag or enable clear releases pin
// (R15) one shared open-drain pin, readable flags
// (R16) polling host clears all interrupt enables
// (R17) comp interval field selects period, resets 01
// (R18) backup bits zero; first check after 1s
// (R19) window field sets comparator on time
// (R20) detector off: switch held by bypass bit
// (R21) check each second, pick normal or backup
// (R22) host checks oscillator flag before setting time
// (R23) timer pulse lasts at least 7.813 ms
// (R24) timer periods from 244.14 us upward
// (R25) flags cleared by zero, kept by one
`timescale 1ns/1ps

module rtc_irq_backup
  import rtc_irq_pkg::*;
#(
  parameter int PULSE_CYCLES = IRQ_PULSE_CYCLES,
  parameter int WIN_CYCLES = WIN_UNIT_CYCLES,
  parameter int TICK_LEN = TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic linkClk,
  input wire logic [7:0] linkAddr,
  input wire logic linkWrite,
  input wire logic [7:0] linkWdata,
  input wire logic linkReq,
  output logic linkBusy,
  output logic [7:0] linkRdata,
  output logic linkDone,
  input wire logic minuteMatch,
  input wire logic hourMatch,
  input wire logic dayMatch,
  input wire logic dateMatch,
  input wire logic supplyAbove,
  input wire logic oscStopped,
  input wire logic irqNIn,
  output logic irqNOut,
  output logic irqNOe,
  output logic compTrigger,
  output logic comparatorOn,
  output logic bypassSwitchOn,
  output logic backupMode
);

  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int WW = $clog2(WIN_CYCLES * 128 + 1);
  localparam int TW = $clog2(TICK_LEN + 1);

  // reset synchronisers, one per domain
  logic [1:0] rstSync_q;
  logic [1:0] linkRstSync_q;
  logic rstCore_b;
  logic linkRst_b;

  // link-side holding registers and handshake
  logic [7:0] holdAddr_q;
  logic holdWrite_q;
  logic [7:0] holdData_q;
  logic reqTgl_q;
  logic pend_q;
  logic [1:0] ackSync_q;
  logic ackSeen_q;
  logic [7:0] linkRdata_q;
  logic linkDone_q;

  // core-side handshake
  logic [1:0] reqSync_q;
  logic reqSeen_q;
  logic reqEdge;
  logic ackTgl_q;
  logic [7:0] rdHold_q;
  logic [7:0] rdMux;

  // decoded writes
  logic wrStb;
  logic wrCtrl;
  logic wrExt;
  logic wrFlag;
  logic wrBackup;
  logic wrTimLo;
  logic wrTimHi;

  // registers
  logic [7:0] ctrl_q;
  logic [7:0] ext_q;
  logic [7:0] backup_q;
  logic [11:0] preset_q;
  logic tFlag_q;
  logic uFlag_q;
  logic aFlag_q;
  logic vlFlag_q;
  logic [1:0] oscSync_q;
  logic [1:0] supSync_q;

  // time base
  logic [TW-1:0] tickDiv_q;
  logic tick;
  logic [11:0] tickIdx_q;
  logic tick64;
  logic halfTick;
  logic secTick;
  logic minTick;
  logic [5:0] secCnt_q;
  logic [1:0] minDly_q;

  // event sources
  logic timerRun;
  logic srcTick;
  logic [11:0] timerCnt_q;
  logic tEvent;
  logic uEvent;
  logic aMatch;
  logic aEvent;
  logic [PW-1:0] tPulse_q;
  logic [PW-1:0] uPulse_q;

  // compensation and backup
  logic [6:0] compCnt_q;
  logic compTrig_q;
  backup_state_type bkState_q;
  logic [WW-1:0] winCnt_q;
  logic detEnable;

  // compensation period in half seconds
  function automatic logic [6:0] compHalves(input logic [1:0] sel);
    case (sel)
      2'h0: compHalves = COMP_HALVES_0;
      2'h1: compHalves = COMP_HALVES_1;
      2'h2: compHalves = COMP_HALVES_2;
      default: compHalves = COMP_HALVES_3;
    endcase
  endfunction

  // detection window length in clock cycles, minus one
  function automatic logic [WW-1:0] winLast(input logic [1:0] sel);
    logic [7:0] units;
    case (sel)
      2'h0: units = WIN_UNITS_0;
      2'h1: units = WIN_UNITS_1;
      2'h2: units = WIN_UNITS_2;
      default: units = WIN_UNITS_3;
    endcase
    winLast = WW'(units * WIN_CYCLES - 1);
  endfunction

  // reset release through two flops in each domain
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rstSync_q <= 2'h0;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstCore_b = rstSync_q[1];

  always_ff @(posedge linkClk or negedge rst_b)
  begin
    if (!rst_b)
      linkRstSync_q <= 2'h0;
    else
      linkRstSync_q <= {linkRstSync_q[0], 1'b1};
  end
  assign linkRst_b = linkRstSync_q[1];

  // link side: latch request, toggle to core, wait for ack toggle
  always_ff @(posedge linkClk or negedge linkRst_b)
  begin
    if (!linkRst_b)
    begin
      holdAddr_q <= 8'h00;
      holdWrite_q <= 1'b0;
      holdData_q <= 8'h00;
      reqTgl_q <= 1'b0;
      pend_q <= 1'b0;
      ackSync_q <= 2'h0;
      ackSeen_q <= 1'b0;
      linkRdata_q <= 8'h00;
      linkDone_q <= 1'b0;
    end
    else
    begin
      ackSync_q <= {ackSync_q[0], ackTgl_q};
      ackSeen_q <= ackSync_q[1];
      linkDone_q <= 1'b0;
      // hold registers stay still while pending, so core may read them
      if (linkReq && !pend_q)
      begin
        holdAddr_q <= linkAddr;
        holdWrite_q <= linkWrite;
        holdData_q <= linkWdata;
        reqTgl_q <= ~reqTgl_q;
        pend_q <= 1'b1;
      end
      else if (ackSync_q[1] != ackSeen_q)
      begin
        // rdHold_q was settled on the same edge that toggled the ack
        linkRdata_q <= rdHold_q;
        linkDone_q <= 1'b1;
        pend_q <= 1'b0;
      end
    end
  end
  assign linkBusy = pend_q;
  assign linkRdata = linkRdata_q;
  assign linkDone = linkDone_q;

  // core side: detect request toggle, answer with ack toggle
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
    begin
      reqSync_q <= 2'h0;
      reqSeen_q <= 1'b0;
      ackTgl_q <= 1'b0;
      rdHold_q <= 8'h00;
    end
    else
    begin
      reqSync_q <= {reqSync_q[0], reqTgl_q};
      reqSeen_q <= reqSync_q[1];
      if (reqEdge)
      begin
        rdHold_q <= rdMux;
        ackTgl_q <= ~ackTgl_q;
      end
    end
  end
  assign reqEdge = reqSync_q[1] ^ reqSeen_q;

  // write decode
  assign wrStb = reqEdge && holdWrite_q;
  assign wrCtrl = wrStb &&
    (holdAddr_q == ADDR_CTRL || holdAddr_q == ADDR_CTRL_MIRROR);
  assign wrExt = wrStb && holdAddr_q == ADDR_EXT;
  assign wrFlag = wrStb && holdAddr_q == ADDR_FLAG;
  assign wrBackup = wrStb && holdAddr_q == ADDR_BACKUP;
  assign wrTimLo = wrStb && holdAddr_q == ADDR_TIMER_LO;
  assign wrTimHi = wrStb && holdAddr_q == ADDR_TIMER_HI;

  // read decode; unmapped offsets read zero
  always_comb
  begin
    rdMux = 8'h00;
    if (holdAddr_q == ADDR_CTRL || holdAddr_q == ADDR_CTRL_MIRROR)
      rdMux = ctrl_q;
    else if (holdAddr_q == ADDR_EXT)
      rdMux = ext_q;
    else if (holdAddr_q == ADDR_FLAG)
    begin
      rdMux[FLAG_BACKUP] = backupMode;
      rdMux[FLAG_UF] = uFlag_q; // R15
      rdMux[FLAG_TF] = tFlag_q;
      rdMux[FLAG_AF] = aFlag_q;
      rdMux[FLAG_VLF] = vlFlag_q;
    end
    else if (holdAddr_q == ADDR_BACKUP)
      rdMux = backup_q;
    else if (holdAddr_q == ADDR_TIMER_LO)
      rdMux = preset_q[7:0];
    else if (holdAddr_q == ADDR_TIMER_HI)
      rdMux = {4'h0, preset_q[11:8]};
  end

  // control-type registers; unused bits stay zero
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
    begin
      ctrl_q <= CTRL_RESET; // R17
      ext_q <= EXT_RESET;
      backup_q <= BK_RESET; // R18
      preset_q <= 12'h000;
    end
    else
    begin
      if (wrCtrl)
        ctrl_q <= holdData_q & CTRL_WMASK;
      if (wrExt)
        ext_q <= holdData_q & EXT_WMASK;
      if (wrBackup)
        backup_q <= holdData_q & BK_WMASK;
      if (wrTimLo)
        preset_q[7:0] <= holdData_q;
      if (wrTimHi)
        preset_q[11:8] <= holdData_q[3:0];
    end
  end

  // sticky flags: an event in the clearing cycle wins
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
    begin
      tFlag_q <= 1'b0;
      uFlag_q <= 1'b0;
      aFlag_q <= 1'b0;
      vlFlag_q <= 1'b1;
    end
    else
    begin
      tFlag_q <= tEvent ||
        (tFlag_q && !(wrFlag && !holdData_q[FLAG_TF])); // R3 R25
      uFlag_q <= uEvent ||
        (uFlag_q && !(wrFlag && !holdData_q[FLAG_UF])); // R9 R25
      aFlag_q <= aEvent ||
        (aFlag_q && !(wrFlag && !holdData_q[FLAG_AF])); // R13 R25
      vlFlag_q <= oscSync_q[1] ||
        (vlFlag_q && !(wrFlag && !holdData_q[FLAG_VLF]));
    end
  end

  // pin inputs through two flops
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
    begin
      oscSync_q <= 2'h0;
      supSync_q <= 2'h0;
    end
    else
    begin
      oscSync_q <= {oscSync_q[0], oscStopped};
      supSync_q <= {supSync_q[0], supplyAbove};
    end
  end

  // 4096 Hz tick and its index within the second
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
    begin
      tickDiv_q <= '0;
      tickIdx_q <= 12'h000;
    end
    else if (tick)
    begin
      tickDiv_q <= '0;
      tickIdx_q <= tickIdx_q + 12'h001;
    end
    else
      tickDiv_q <= tickDiv_q + TW'(1);
  end
  assign tick = tickDiv_q == TW'(TICK_LEN - 1);
  assign tick64 = tick && (tickIdx_q & TICK_64HZ_MASK) == TICK_64HZ_MASK;
  assign halfTick = tick && (tickIdx_q & TICK_HALF_MASK) == TICK_HALF_MASK;
  assign secTick = tick && tickIdx_q == TICK_SEC_MASK;
  assign minTick = secTick && secCnt_q == SEC_LAST;

  // seconds within the minute, and minute tick delay for the compare
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
    begin
      secCnt_q <= 6'h00;
      minDly_q <= 2'h0;
    end
    else
    begin
      // calendar settles a cycle after the minute advances
      minDly_q <= {minDly_q[0], minTick};
      if (minTick)
        secCnt_q <= 6'h00;
      else if (secTick)
        secCnt_q <= secCnt_q + 6'h01;
    end
  end

  // source clock of the countdown
  always_comb
  begin
    case (ext_q[EXT_SRC_LSB +: 2])
      SRC_4096HZ: srcTick = tick; // R24
      SRC_64HZ: srcTick = tick64;
      SRC_SECOND: srcTick = secTick;
      default: srcTick = minTick;
    endcase
  end

  // countdown: follows preset while stopped, so a start loads it
  assign timerRun = ext_q[EXT_RUN];
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
      timerCnt_q <= 12'h000;
    else if (!timerRun)
      timerCnt_q <= preset_q; // R1 R6
    else if (srcTick)
    begin
      if (timerCnt_q <= 12'h001)
        timerCnt_q <= preset_q; // R2
      else
        timerCnt_q <= timerCnt_q - 12'h001;
    end
  end
  // zero preset never fires
  assign tEvent = timerRun && srcTick && timerCnt_q == 12'h001;

  // timer pulse on the pin
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
      tPulse_q <= '0;
    else if (!timerRun || !ctrl_q[CTRL_TIE])
      tPulse_q <= '0; // R6 R7
    else if (tEvent)
      tPulse_q <= PW'(PULSE_CYCLES); // R4 R5 R23
    else if (tPulse_q != '0)
      tPulse_q <= tPulse_q - PW'(1);
  end

  // update event: seconds or minutes
  assign uEvent = ext_q[EXT_UPDATE_PERIOD_SEL] ? minTick : secTick; // R8
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
      uPulse_q <= '0;
    else if (!ctrl_q[CTRL_UIE])
      uPulse_q <= '0; // R11
    else if (uEvent)
      uPulse_q <= PW'(PULSE_CYCLES); // R10
    else if (uPulse_q != '0)
      uPulse_q <= uPulse_q - PW'(1);
  end

  // alarm only checked right after the minute advances
  assign aMatch = minuteMatch && hourMatch &&
    (ext_q[EXT_DAYDATE] ? dateMatch : dayMatch);
  assign aEvent = minDly_q[1] && aMatch; // R12

  // shared open-drain pin, only ever pulled low; irqNIn not needed
  assign irqNOut = 1'b0;
  assign irqNOe = tPulse_q != '0 || uPulse_q != '0 ||
    (aFlag_q && ctrl_q[CTRL_AIE]); // R13 R14 R15

  // temperature compensation trigger
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
    begin
      compCnt_q <= 7'h00;
      compTrig_q <= 1'b0;
    end
    else
    begin
      compTrig_q <= 1'b0;
      if (halfTick)
      begin
        if (compCnt_q + 7'h01 >= compHalves(ctrl_q[7:CTRL_COMP_LSB]))
        begin
          compCnt_q <= 7'h00;
          compTrig_q <= 1'b1; // R17
        end
        else
          compCnt_q <= compCnt_q + 7'h01;
      end
    end
  end
  assign compTrigger = compTrig_q;

  // supply check once a second, decision at window end
  assign detEnable = !backup_q[BK_DETOFF];
  always_ff @(posedge clk or negedge rstCore_b)
  begin
    if (!rstCore_b)
    begin
      bkState_q <= BK_NORMAL;
      winCnt_q <= '0;
    end
    else if (!detEnable)
    begin
      bkState_q <= BK_NORMAL; // R20
      winCnt_q <= '0;
    end
    else
    begin
      case (bkState_q)
        BK_MEASURE:
        begin
          if (winCnt_q == '0)
            bkState_q <= supSync_q[1] ? BK_NORMAL : BK_BACKUP; // R19 R21
          else
            winCnt_q <= winCnt_q - WW'(1);
        end
        default:
        begin
          // first second tick comes one second after reset
          if (secTick)
          begin
            bkState_q <= BK_MEASURE; // R18 R21
            winCnt_q <= winLast(backup_q[BK_WIN_LSB +: 2]); // R19
          end
        end
      endcase
    end
  end
  assign comparatorOn = detEnable && bkState_q == BK_MEASURE;
  assign bypassSwitchOn = detEnable ? bkState_q == BK_NORMAL
    : !backup_q[BK_BYPASS_SWITCH_DISABLE]; // R20 R21
  assign backupMode = detEnable && bkState_q == BK_BACKUP;

  // checks on the core domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstCore_b);

  timer_start_a: assert property ( // R1
    !timerRun |=> timerCnt_q == $past(preset_q))
    else $error("countdown not loaded from preset");
  timer_reload_a: assert property ( // R2
    tEvent |=> timerCnt_q == $past(preset_q))
    else $error("countdown not reloaded");
  tflag_set_a: assert property (tEvent |=> tFlag_q) // R3
    else $error("timer flag not set");
  tpulse_len_a: assert property ( // R4
    tEvent && ctrl_q[CTRL_TIE] |=>
    irqNOe && tPulse_q == PW'(PULSE_CYCLES))
    else $error("timer pulse wrong length");
  tpulse_end_a: assert property ( // R5
    tPulse_q == PW'(1) && !tEvent |=> tPulse_q == '0)
    else $error("timer pulse not released");
  // the pulse counter sees a cleared control bit one edge later
  tstop_a: assert property ($fell(timerRun) |=> tPulse_q == '0) // R6
    else $error("stopped timer still pulling pin");
  tie_clear_a: assert property ( // R7
    $fell(ctrl_q[CTRL_TIE]) |=> tPulse_q == '0)
    else $error("timer enable clear did not release");
  uflag_set_a: assert property (uEvent |=> uFlag_q) // R9
    else $error("update flag not set");
  upulse_len_a: assert property ( // R10
    uEvent && ctrl_q[CTRL_UIE] |=> uPulse_q == PW'(PULSE_CYCLES))
    else $error("update pulse wrong length");
  alarm_rel_a: assert property ( // R14
    !(aFlag_q && ctrl_q[CTRL_AIE]) && tPulse_q == '0 && uPulse_q == '0
    |-> !irqNOe)
    else $error("pin low with no cause");
  measure_sw_a: assert property ( // R21
    bkState_q == BK_MEASURE && detEnable |-> comparatorOn && !bypassSwitchOn)
    else $error("switch closed during measurement");
  flag_keep_a: assert property ( // R25
    tFlag_q && wrFlag && holdData_q[FLAG_TF] |=> tFlag_q)
    else $error("timer flag lost on write of one");

  timer_irq_c: cover property (tEvent && ctrl_q[CTRL_TIE]);
  alarm_irq_c: cover property (aEvent && ctrl_q[CTRL_AIE]);
  backup_c: cover property (
    bkState_q == BK_MEASURE ##1 bkState_q == BK_BACKUP);

endmodule

// File: rtc_irq_pkg.sv
// constants for the clock interrupt and backup-switch control block
// assumes a 10 MHz core clock and a byte-wide register port
package rtc_irq_pkg;

  // register offsets
  localparam logic [7:0] ADDR_TIMER_LO = 8'h0B;
  localparam logic [7:0] ADDR_TIMER_HI = 8'h0C;
  localparam logic [7:0] ADDR_EXT = 8'h0D;
  localparam logic [7:0] ADDR_FLAG = 8'h0E;
  localparam logic [7:0] ADDR_CTRL = 8'h0F;
  localparam logic [7:0] ADDR_CTRL_MIRROR = 8'h1F;
  localparam logic [7:0] ADDR_BACKUP = 8'h18;

  // control register fields
  localparam int CTRL_COMP_LSB = 6;
  localparam int CTRL_UIE = 5;
  localparam int CTRL_TIE = 4;
  localparam int CTRL_AIE = 3;
  localparam logic [7:0] CTRL_WMASK = 8'hF8;
  localparam logic [7:0] CTRL_RESET = 8'h40;

  // extension register fields
  localparam int EXT_DAYDATE = 6;
  localparam int EXT_UPDATE_PERIOD_SEL = 5;
  localparam int EXT_RUN = 4;
  localparam int EXT_SRC_LSB = 0;
  localparam logic [7:0] EXT_WMASK = 8'h73;
  localparam logic [7:0] EXT_RESET = 8'h00;

  // flag register fields
  localparam int FLAG_BACKUP = 7;
  localparam int FLAG_UF = 5;
  localparam int FLAG_TF = 4;
  localparam int FLAG_AF = 3;
  localparam int FLAG_VLF = 1;

  // backup register fields
  localparam int BK_DETOFF = 3;
  localparam int BK_BYPASS_SWITCH_DISABLE = 2;
  localparam int BK_WIN_LSB = 0;
  localparam logic [7:0] BK_WMASK = 8'h0F;
  localparam logic [7:0] BK_RESET = 8'h00;

  // timer source clock codes
  localparam logic [1:0] SRC_4096HZ = 2'h0;
  localparam logic [1:0] SRC_64HZ = 2'h1;
  localparam logic [1:0] SRC_SECOND = 2'h2;
  localparam logic [1:0] SRC_MINUTE = 2'h3;

  // time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 244_140;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [11:0] TICK_64HZ_MASK = 12'h003F;
  localparam logic [11:0] TICK_HALF_MASK = 12'h07FF;
  localparam logic [11:0] TICK_SEC_MASK = 12'h0FFF;
  localparam logic [5:0] SEC_LAST = 6'h3B;

  // interrupt pulse width, least time so rounded up
  localparam int IRQ_PULSE_NS = 7_813_000;
  localparam int IRQ_PULSE_CYCLES =
    (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // compensation periods in half seconds
  localparam logic [6:0] COMP_HALVES_0 = 7'h01;
  localparam logic [6:0] COMP_HALVES_1 = 7'h04;
  localparam logic [6:0] COMP_HALVES_2 = 7'h14;
  localparam logic [6:0] COMP_HALVES_3 = 7'h3C;

  // detection windows in units of 2 ms
  localparam int WIN_UNIT_NS = 2_000_000;
  localparam int WIN_UNIT_CYCLES = WIN_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] WIN_UNITS_0 = 8'h01;
  localparam logic [7:0] WIN_UNITS_1 = 8'h08;
  localparam logic [7:0] WIN_UNITS_2 = 8'h40;
  localparam logic [7:0] WIN_UNITS_3 = 8'h80;

  // supply check states, gray along the usual path
  typedef enum logic [1:0]
  {
    BK_NORMAL = 2'b00,
    BK_MEASURE = 2'b01,
    BK_BACKUP = 2'b11
  } backup_state_type;

endpackage

// File: rtc_host_model.sv
// host-side model of the byte register port on the link clock
// assumes one request at a time, next one after the done pulse
`timescale 1ns/1ps

module rtc_host_model
(
  input wire logic linkClk,
  input wire logic linkBusy,
  input wire logic [7:0] linkRdata,
  input wire logic linkDone,
  output logic [7:0] linkAddr,
  output logic linkWrite,
  output logic [7:0] linkWdata,
  output logic linkReq
);
  // idle values at time zero
  initial
  begin
    linkAddr = 8'h00;
    linkWrite = 1'b0;
    linkWdata = 8'h00;
    linkReq = 1'b0;
  end

  // one transfer; request held until the taking edge
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    begin
      @(posedge linkClk);
      linkAddr <= a;
      linkWrite <= wr;
      linkWdata <= d;
      linkReq <= 1'b1;
      // taken where busy is seen low with the request up
      do @(posedge linkClk); while (linkBusy !== 1'b0);
      linkReq <= 1'b0;
      // read data is settled at the done edge
      do @(posedge linkClk); while (linkDone !== 1'b1);
      q = linkRdata;
      // released lines show no stale value
      linkAddr <= ~a;
      linkWdata <= ~d;
      linkWrite <= ~wr;
    end
  endtask
endmodule

// File: rtc_interrupt_backup_ctrl_tb.sv
// self-checking bench for the interrupt and backup-switch block
// assumes the host model drives the register port on linkClk
`timescale 1ns/1ps

module rtc_interrupt_backup_ctrl_tb;
  import rtc_irq_pkg::*;
  // shortened counts; a second is TICK * 4096 cycles
  localparam int PULSE = 20;
  localparam int WIN = 4;
  localparam int TICK = 2;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] linkAddr, linkWdata, linkRdata;
  logic linkWrite, linkReq, linkBusy, linkDone;
  logic supplyAbove = 1'b0;
  logic zeroLvl = 1'b0; // alarm matches: a minute is too long here
  logic irqNOut, irqNOe, irqNIn, compTrigger;
  logic comparatorOn, bypassSwitchOn, backupMode;
  int errCount = 0;
  int totalChecks = 0;
  int cyc = 0;
  int winCnt = 0;
  int winLen = 0;
  int lastTrig = 0;
  int trigGap = 0;
  int trigCnt = 0;
  int n;

  always #50 clk = ~clk;
  always #15 linkClk = ~linkClk;
  // pulled-up open-drain wire
  assign irqNIn = irqNOe ? 1'b0 : 1'b1;

  rtc_irq_backup #(.PULSE_CYCLES(PULSE), .WIN_CYCLES(WIN),
    .TICK_LEN(TICK)) uut (.clk(clk), .rst_b(rst_b),
    .linkClk(linkClk), .linkAddr(linkAddr), .linkWrite(linkWrite),
    .linkWdata(linkWdata), .linkReq(linkReq), .linkBusy(linkBusy),
    .linkRdata(linkRdata), .linkDone(linkDone),
    .minuteMatch(zeroLvl), .hourMatch(zeroLvl), .dayMatch(zeroLvl),
    .dateMatch(zeroLvl), .supplyAbove(supplyAbove),
    .oscStopped(zeroLvl), .irqNIn(irqNIn), .irqNOut(irqNOut),
    .irqNOe(irqNOe), .compTrigger(compTrigger),
    .comparatorOn(comparatorOn), .bypassSwitchOn(bypassSwitchOn),
    .backupMode(backupMode));

  rtc_host_model host (.linkClk(linkClk), .linkBusy(linkBusy),
    .linkRdata(linkRdata), .linkDone(linkDone), .linkAddr(linkAddr),
    .linkWrite(linkWrite), .linkWdata(linkWdata), .linkReq(linkReq));

  // window length and compensation spacing monitors
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (comparatorOn === 1'b1)
      winCnt <= winCnt + 1;
    else if (winCnt != 0)
    begin
      winLen <= winCnt;
      winCnt <= 0;
    end
    if (compTrigger === 1'b1)
    begin
      trigGap <= cyc - lastTrig;
      lastTrig <= cyc;
      trigCnt <= trigCnt + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      totalChecks++;
      if (got !== exp)
      begin
        errCount++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    begin
      host.xfer(1'b1, a, d, q);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    begin
      host.xfer(1'b0, a, 8'h00, q);
      chk({8'h00, q}, {8'h00, e});
    end
  endtask

  // counts clk edges until the pin enable reaches lvl, capped at lim
  task automatic waitIrq(input logic lvl, input int lim, output int c);
    begin
      c = 0;
      do
      begin
        @(posedge clk);
        c++;
      end
      while (irqNOe !== lvl && c < lim);
    end
  endtask

  task automatic closeOut();
    begin
      $display("checks %0d errors %0d", totalChecks, errCount);
      if (errCount == 0 && totalChecks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // hang guard, well beyond the expected run
  initial
  begin
    #6_000_000;
    errCount++;
    closeOut();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    // reset values, unmapped place
    rd(ADDR_FLAG, 8'h02);
    rd(ADDR_CTRL, 8'h40);
    rd(ADDR_BACKUP, 8'h00);
    rd(ADDR_EXT, 8'h00);
    rd(8'h05, 8'h00);
    wr(ADDR_FLAG, 8'h00);
    rd(ADDR_FLAG, 8'h00);
    chk(irqNOut, 1'b0);
    // timer: preset 40 ticks of two cycles
    wr(ADDR_TIMER_LO, 8'h28);
    wr(ADDR_TIMER_HI, 8'h00);
    rd(ADDR_TIMER_LO, 8'h28);
    wr(ADDR_CTRL, 8'h50);
    wr(ADDR_EXT, 8'h10);
    waitIrq(1'b1, 400, n);
    chk(n < 400, 1'b1);
    waitIrq(1'b0, 40, n);
    chk(n, PULSE);
    waitIrq(1'b1, 200, n);
    chk(n, 80 - PULSE);
    // flag clear mid-pulse leaves the pin low
    wr(ADDR_FLAG, 8'h00);
    chk(irqNOe, 1'b1);
    rd(ADDR_FLAG, 8'h00);
    // enable clear mid-pulse releases the pin; let this pulse end first
    waitIrq(1'b0, 40, n);
    waitIrq(1'b1, 200, n);
    wr(ADDR_CTRL, 8'h40);
    repeat (2) @(posedge clk);
    chk(irqNOe, 1'b0);
    wr(ADDR_FLAG, 8'h10);
    rd(ADDR_FLAG, 8'h10);
    // masked event: flag only, polled
    wr(ADDR_FLAG, 8'h00);
    waitIrq(1'b1, 100, n);
    chk(n, 100);
    rd(ADDR_FLAG, 8'h10);
    // run off mid-pulse stops timer and pin
    wr(ADDR_CTRL, 8'h50);
    waitIrq(1'b1, 200, n);
    wr(ADDR_EXT, 8'h00);
    repeat (2) @(posedge clk);
    chk(irqNOe, 1'b0);
    wr(ADDR_FLAG, 8'h00);
    waitIrq(1'b1, 200, n);
    chk(n, 200);
    rd(ADDR_FLAG, 8'h00);
    // seconds update with supply below threshold
    wr(ADDR_CTRL, 8'h60);
    waitIrq(1'b1, 9000, n);
    chk(n < 9000, 1'b1);
    waitIrq(1'b0, 40, n);
    chk(n, PULSE);
    rd(ADDR_FLAG, 8'hA0);
    chk(winLen, WIN);
    chk({backupMode, bypassSwitchOn}, 2'b10);
    // supply back, 16 ms window, enable clear mid-pulse
    @(posedge clk);
    supplyAbove <= 1'b1;
    wr(ADDR_BACKUP, 8'h01);
    wr(ADDR_FLAG, 8'h00);
    waitIrq(1'b1, 9000, n);
    wr(ADDR_FLAG, 8'h00);
    chk(irqNOe, 1'b1);
    wr(ADDR_CTRL, 8'h40);
    repeat (2) @(posedge clk);
    chk(irqNOe, 1'b0);
    repeat (40) @(posedge clk);
    chk(winLen, WIN * 8);
    chk({backupMode, bypassSwitchOn}, 2'b01);
    // detector off: switch follows bypass bit
    wr(ADDR_BACKUP, 8'h08);
    repeat (4) @(posedge clk);
    chk(bypassSwitchOn, 1'b1);
    wr(ADDR_BACKUP, 8'h0C);
    repeat (4) @(posedge clk);
    chk(bypassSwitchOn, 1'b0);
    // half-second compensation interval
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h00);
    n = trigCnt;
    repeat (30000)
    begin
      if (trigCnt < n + 3)
        @(posedge clk);
    end
    chk(trigGap, TICK * 2048);
    closeOut();
  end
endmodule
